/* File: rtl/reload_timer_pkg.sv */
/*
 * constants, register map and carrier types for the reload timer.
 * assumes a single system clock and an 8-bit special function register port.
 */
package reload_timer_pkg;
    // register offsets
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;
    // timer_control field positions
    localparam int BIT_HIGH_FLAG  = 7;
    localparam int BIT_LOW_FLAG   = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_SPLIT      = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_EXT_CLK    = 0;
    localparam logic [7:0] CONTROL_RW_MASK = 8'hed; // bits 4 and 1 read 0
    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // rollover points
    localparam logic [7:0] BYTE_MAX = 8'hff;
    // clock divisors
    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

    // one register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;      // byte write
        logic [7:0] wdata;
        logic       bit_wr;  // single-bit write, control register only
        logic [2:0] bit_idx;
        logic       bit_val;
        logic       rd;
    } sfr_req_t;
endpackage

/* File: rtl/timer_tick_gen.sv */
/*
 * count tick generator: system clock / 12 and synchronised external / 8.
 * assumes ext_osc toggles no faster than half the system clock.
 */
`timescale 1ns/10ps
module timer_tick_gen (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic ext_osc,
    output logic      tick_div12,
    output logic      tick_ext8
);
    logic [3:0] div12_reg;
    logic       sync1_reg;
    logic       sync2_reg;
    logic       prev_reg;
    logic [2:0] ext_cnt_reg;
    logic       ext_rise;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div12_reg  <= 4'h0;
            tick_div12 <= 1'b0;
        end else begin
            tick_div12 <= (div12_reg == reload_timer_pkg::SYS_DIV_LAST);
            if (div12_reg == reload_timer_pkg::SYS_DIV_LAST)
                div12_reg <= 4'h0;
            else
                div12_reg <= div12_reg + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= ext_osc;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    assign ext_rise = sync2_reg & ~prev_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_cnt_reg <= 3'h0;
            tick_ext8   <= 1'b0;
        end else begin
            tick_ext8 <= ext_rise
                && (ext_cnt_reg == reload_timer_pkg::EXT_DIV_LAST);
            if (ext_rise)
                ext_cnt_reg <= ext_cnt_reg + 3'h1;
        end
    end
endmodule // timer_tick_gen

/* File: rtl/reload_timer_split_mode.sv */
/*
 * 16-bit / split 8-bit auto-reload timer with its control register.
 * assumes a core drives one sfr_req_t per clock; clock select bits and the
 * timer interrupt enable come from core logic on the same clock.
 */
`timescale 1ns/10ps
module reload_timer_split_mode (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire reload_timer_pkg::sfr_req_t  sfr_req,
    input  wire logic                        high_sysclk_select,
    input  wire logic                        low_sysclk_select,
    input  wire logic                        timer_irq_enable,
    input  wire logic                        ext_osc,
    output logic [7:0]                       sfr_rdata,
    output logic                             irq_req
);
    logic [7:0] control_reg;
    logic [7:0] count_low_reg;
    logic [7:0] count_high_reg;
    logic [7:0] reload_low_reg;
    logic [7:0] reload_high_reg;
    logic [7:0] count_low_next;
    logic [7:0] count_high_next;
    logic       tick_div12;
    logic       tick_ext8;
    logic       tick_h;
    logic       tick_l;
    logic       split;
    logic       run;
    logic       inc16;
    logic       inc_h;
    logic       inc_l;
    logic       ovf_high;
    logic       ovf_low;
    logic       ctl_wr;
    logic       cnt_wr;
    logic [7:0] control_wr_val;

    timer_tick_gen u_tick (
        .clock      (clock),
        .rstn       (rstn),
        .ext_osc    (ext_osc),
        .tick_div12 (tick_div12),
        .tick_ext8  (tick_ext8)
    );

    // selects a count tick from the encoding shared by both bytes
    function automatic logic pick_tick(input logic sys_sel,
                                       input logic ext_sel,
                                       input logic t12,
                                       input logic t8);
        pick_tick = sys_sel ? 1'b1 : (ext_sel ? t8 : t12);
    endfunction

    assign tick_h = pick_tick(high_sysclk_select,
                              control_reg[reload_timer_pkg::BIT_EXT_CLK],
                              tick_div12, tick_ext8);
    assign tick_l = pick_tick(low_sysclk_select,
                              control_reg[reload_timer_pkg::BIT_EXT_CLK],
                              tick_div12, tick_ext8);

    assign split = control_reg[reload_timer_pkg::BIT_SPLIT];
    assign run   = control_reg[reload_timer_pkg::BIT_RUN];
    assign inc16 = !split && run && tick_h;
    assign inc_h = split && run && tick_h;
    assign inc_l = split && tick_l;

    assign ovf_high = (inc16 && count_high_reg == reload_timer_pkg::BYTE_MAX
                       && count_low_reg == reload_timer_pkg::BYTE_MAX)
                   || (inc_h && count_high_reg == reload_timer_pkg::BYTE_MAX);
    assign ovf_low  = (inc16 || inc_l)
                   && count_low_reg == reload_timer_pkg::BYTE_MAX;

    assign ctl_wr = sfr_req.addr == reload_timer_pkg::ADDR_TIMER_CONTROL
                 && (sfr_req.wr || sfr_req.bit_wr);
    assign cnt_wr = sfr_req.wr
        && (sfr_req.addr == reload_timer_pkg::ADDR_COUNT_LOW
         || sfr_req.addr == reload_timer_pkg::ADDR_COUNT_HIGH);

    // next count values: increment, reload on rollover
    always_comb begin
        count_low_next  = count_low_reg;
        count_high_next = count_high_reg;
        if (inc16) begin
            // 16-bit reload from both reload bytes
            if (ovf_high) begin
                count_low_next  = reload_low_reg;
                count_high_next = reload_high_reg;
            end else begin
                count_low_next = count_low_reg + 8'h01;
                if (ovf_low)
                    count_high_next = count_high_reg + 8'h01;
            end
        end else begin
            if (inc_l)
                count_low_next = ovf_low ? reload_low_reg
                                         : count_low_reg + 8'h01;
            if (inc_h)
                count_high_next = ovf_high ? reload_high_reg
                                           : count_high_reg + 8'h01;
        end
    end

    // count bytes: a core write takes priority over counting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_low_reg  <= reload_timer_pkg::RESET_BYTE;
            count_high_reg <= reload_timer_pkg::RESET_BYTE;
        end else begin
            count_low_reg  <= count_low_next;
            count_high_reg <= count_high_next;
            if (sfr_req.wr
                && sfr_req.addr == reload_timer_pkg::ADDR_COUNT_LOW)
                count_low_reg <= sfr_req.wdata;
            if (sfr_req.wr
                && sfr_req.addr == reload_timer_pkg::ADDR_COUNT_HIGH)
                count_high_reg <= sfr_req.wdata;
        end
    end

    // reload bytes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reload_low_reg  <= reload_timer_pkg::RESET_BYTE;
            reload_high_reg <= reload_timer_pkg::RESET_BYTE;
        end else begin
            if (sfr_req.wr
                && sfr_req.addr == reload_timer_pkg::ADDR_RELOAD_LOW)
                reload_low_reg <= sfr_req.wdata;
            if (sfr_req.wr
                && sfr_req.addr == reload_timer_pkg::ADDR_RELOAD_HIGH)
                reload_high_reg <= sfr_req.wdata;
        end
    end

    // byte or single-bit write value for the control register
    always_comb begin
        control_wr_val = control_reg;
        if (sfr_req.wr)
            control_wr_val = sfr_req.wdata;
        else if (sfr_req.bit_wr)
            control_wr_val[sfr_req.bit_idx] = sfr_req.bit_val;
        control_wr_val = control_wr_val & reload_timer_pkg::CONTROL_RW_MASK;
    end

    // control register; hardware flag set wins over a same-cycle clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            control_reg <= reload_timer_pkg::RESET_CONTROL;
        end else begin
            if (ctl_wr)
                control_reg <= control_wr_val;
            // hardware only ever sets the flags; core writes can set or clear them
            if (ovf_high)
                control_reg[reload_timer_pkg::BIT_HIGH_FLAG] <= 1'b1;
            if (ovf_low)
                control_reg[reload_timer_pkg::BIT_LOW_FLAG] <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            irq_req <= 1'b0;
        else
            irq_req <= timer_irq_enable
                && (control_reg[reload_timer_pkg::BIT_HIGH_FLAG]
                 || (control_reg[reload_timer_pkg::BIT_LOW_FLAG]
                  && control_reg[reload_timer_pkg::BIT_LOW_IRQ_EN]));
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                reload_timer_pkg::ADDR_TIMER_CONTROL: sfr_rdata <= control_reg;
                reload_timer_pkg::ADDR_RELOAD_LOW:  sfr_rdata <= reload_low_reg;
                reload_timer_pkg::ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_reg;
                reload_timer_pkg::ADDR_COUNT_LOW:   sfr_rdata <= count_low_reg;
                reload_timer_pkg::ADDR_COUNT_HIGH:  sfr_rdata <= count_high_reg;
                default:                            sfr_rdata <= 8'h00;
            endcase
        end
    end

    // checks
    property p_reload16;
        @(posedge clock) disable iff (!rstn)
        inc16 && !cnt_wr && {count_high_reg, count_low_reg} == 16'hffff
        |=> {count_high_reg, count_low_reg}
            == {$past(reload_high_reg), $past(reload_low_reg)};
    endproperty
    a_reload16: assert property (p_reload16)
        else $error("16-bit rollover did not reload");

    property p_high_flag_set;
        @(posedge clock) disable iff (!rstn)
        ovf_high |=> control_reg[7]
            ##1 (irq_req || !$past(timer_irq_enable));
    endproperty
    a_high_flag_set: assert property (p_high_flag_set)
        else $error("high overflow did not set flag or raise request");

    property p_low_irq;
        @(posedge clock) disable iff (!rstn)
        timer_irq_enable && control_reg[6] && control_reg[5] |=> irq_req;
    endproperty
    a_low_irq: assert property (p_low_irq)
        else $error("low byte request missing");

    property p_split_low_reload;
        @(posedge clock) disable iff (!rstn)
        inc_l && !cnt_wr && count_low_reg == 8'hff
        |=> count_low_reg == $past(reload_low_reg) && control_reg[6];
    endproperty
    a_split_low_reload: assert property (p_split_low_reload)
        else $error("split low byte did not reload or flag");

    property p_low_free_run;
        @(posedge clock) disable iff (!rstn)
        split && !run && low_sysclk_select && !cnt_wr && count_low_reg != 8'hff
        |=> count_low_reg == $past(count_low_reg) + 8'h01;
    endproperty
    a_low_free_run: assert property (p_low_free_run)
        else $error("low byte stopped without run");

    property p_high_gated;
        @(posedge clock) disable iff (!rstn)
        split && !run && !cnt_wr |=> $stable(count_high_reg);
    endproperty
    a_high_gated: assert property (p_high_gated)
        else $error("high byte counted while stopped");

    property p_flag_sticky;
        @(posedge clock) disable iff (!rstn)
        control_reg[7] && !ctl_wr |=> control_reg[7];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("high flag cleared by hardware");

    property p_no_irq;
        @(posedge clock) disable iff (!rstn)
        !timer_irq_enable |=> !irq_req;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("request raised while disabled");

    property p_reserved_zero;
        @(posedge clock) disable iff (!rstn)
        sfr_req.rd && sfr_req.addr == 8'hc8
        |=> sfr_rdata[4] == 1'b0 && sfr_rdata[1] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    c_ovf16: cover property (@(posedge clock) disable iff (!rstn)
        inc16 && ovf_high);
    c_split_both: cover property (@(posedge clock) disable iff (!rstn)
        split && ovf_low ##[1:600] ovf_high);
    c_set_beats_clear: cover property (@(posedge clock) disable iff (!rstn)
        ctl_wr && ovf_high);
endmodule // reload_timer_split_mode

/* File: verif/tb_top.sv */
/*
 * self-checking bench for the reload timer: register map, 16-bit and
 * split modes, clock sources and the interrupt request level.
 * assumes the design's own assertions ride along; one 50 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(got, exp) check_val(16'(got), 16'(exp))
module tb_top;
    logic                       clock;
    logic                       rstn;
    reload_timer_pkg::sfr_req_t req;
    logic                       high_sysclk_select;
    logic                       low_sysclk_select;
    logic                       timer_irq_enable;
    logic                       ext_osc;
    logic [7:0]                 sfr_rdata;
    logic                       irq_req;
    int                         errors;
    int                         checked;
    logic [7:0]                 d;

    reload_timer_split_mode reload_timer_split_mode_i (
        .clock              (clock),
        .rstn               (rstn),
        .sfr_req            (req),
        .high_sysclk_select (high_sysclk_select),
        .low_sysclk_select  (low_sysclk_select),
        .timer_irq_enable   (timer_irq_enable),
        .ext_osc            (ext_osc),
        .sfr_rdata          (sfr_rdata),
        .irq_req            (irq_req)
    );

    // clock and external oscillator at half the system rate
    always #10 clock = ~clock;
    always @(posedge clock) ext_osc <= ~ext_osc;

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // byte write, one cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        req.addr  <= a;
        req.wdata <= v;
        req.wr    <= 1'b1;
        @(posedge clock);
        req.wr    <= 1'b0;
    endtask

    // single-bit write to the control register
    task automatic bset(input logic [2:0] idx, input logic v);
        @(posedge clock);
        req.addr    <= reload_timer_pkg::ADDR_TIMER_CONTROL;
        req.bit_idx <= idx;
        req.bit_val <= v;
        req.bit_wr  <= 1'b1;
        @(posedge clock);
        req.bit_wr  <= 1'b0;
    endtask

    // read strobe; data settles after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clock);
        req.rd   <= 1'b0;
        #1 v = sfr_rdata;
    endtask

    // bounded wait for a control bit to come up
    task automatic poll(input logic [7:0] mask);
        for (int i = 0; i < 300; i++) begin
            rd(reload_timer_pkg::ADDR_TIMER_CONTROL, d);
            if ((d & mask) != 8'h00) return;
        end
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, d, mask);
        final_report();
    endtask

    task automatic t_reset_map;
        rd(reload_timer_pkg::ADDR_TIMER_CONTROL, d);
        `CHK(d, 8'h00);
        rd(reload_timer_pkg::ADDR_COUNT_HIGH, d);
        `CHK(d, 8'h00);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h3e);
        rd(reload_timer_pkg::ADDR_TIMER_CONTROL, d);
        `CHK(d, 8'h2c);
        bset(3'h0, 1'b1);
        bset(3'h3, 1'b0);
        rd(reload_timer_pkg::ADDR_TIMER_CONTROL, d);
        `CHK(d, 8'h25);
        rd(8'h00, d);
        `CHK(d, 8'h00);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
        $display("test reset_map done");
    endtask

    // count a window of cycles and return the low byte
    task automatic rate(input logic [7:0] ctl, input int cyc);
        // stop everything first: split mode keeps the low byte running
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
        wr(reload_timer_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(reload_timer_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, ctl);
        repeat (cyc) @(posedge clock);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, ctl & 8'h09);
        rd(reload_timer_pkg::ADDR_COUNT_LOW, d);
    endtask

    task automatic t_sources;
        high_sysclk_select <= 1'b0;
        low_sysclk_select  <= 1'b0;
        // 120 cycles of sysclk/12 gives about ten ticks
        rate(8'h04, 120);
        `CHK(d >= 8'h09 && d <= 8'h0b, 1'b1);
        // external at 25 MHz, /8 ticks every 16 cycles
        rate(8'h05, 160);
        `CHK(d >= 8'h08 && d <= 8'h0b, 1'b1);
        // split mode, run off: low byte still counts, high holds
        rate(8'h08, 120);
        `CHK(d >= 8'h09 && d <= 8'h0b, 1'b1);
        rd(reload_timer_pkg::ADDR_COUNT_HIGH, d);
        `CHK(d, 8'h00);
        rate(8'h09, 160);
        `CHK(d >= 8'h08 && d <= 8'h0b, 1'b1);
        $display("test sources done");
    endtask

    task automatic t_sixteen;
        high_sysclk_select <= 1'b1;
        timer_irq_enable   <= 1'b1;
        wr(reload_timer_pkg::ADDR_RELOAD_LOW, 8'h34);
        wr(reload_timer_pkg::ADDR_RELOAD_HIGH, 8'h12);
        wr(reload_timer_pkg::ADDR_COUNT_LOW, 8'hf0);
        wr(reload_timer_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h04);
        poll(8'h80);
        bset(3'h2, 1'b0);
        rd(reload_timer_pkg::ADDR_COUNT_HIGH, d);
        `CHK(d, 8'h12);
        `CHK(irq_req, 1'b1);
        repeat (50) @(posedge clock);
        rd(reload_timer_pkg::ADDR_TIMER_CONTROL, d);
        `CHK(d, 8'hc0);
        bset(3'h7, 1'b0);
        repeat (2) @(posedge clock);
        `CHK(irq_req, 1'b0);
        bset(3'h5, 1'b1);
        repeat (2) @(posedge clock);
        `CHK(irq_req, 1'b1);
        timer_irq_enable <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(irq_req, 1'b0);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
        $display("test sixteen done");
    endtask

    task automatic t_split;
        high_sysclk_select <= 1'b0;
        low_sysclk_select  <= 1'b1;
        timer_irq_enable   <= 1'b1;
        wr(reload_timer_pkg::ADDR_RELOAD_LOW, 8'hf0);
        wr(reload_timer_pkg::ADDR_RELOAD_HIGH, 8'ha0);
        wr(reload_timer_pkg::ADDR_COUNT_HIGH, 8'h55);
        wr(reload_timer_pkg::ADDR_COUNT_LOW, 8'hf8);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h08);
        poll(8'h40);
        rd(reload_timer_pkg::ADDR_COUNT_LOW, d);
        `CHK(d >= 8'hf0, 1'b1);
        rd(reload_timer_pkg::ADDR_COUNT_HIGH, d);
        `CHK(d, 8'h55);
        `CHK(irq_req, 1'b0);
        bset(3'h5, 1'b1);
        repeat (2) @(posedge clock);
        `CHK(irq_req, 1'b1);
        wr(reload_timer_pkg::ADDR_TIMER_CONTROL, 8'h08);
        wr(reload_timer_pkg::ADDR_COUNT_HIGH, 8'hfe);
        bset(3'h2, 1'b1);
        poll(8'h80);
        bset(3'h2, 1'b0);
        rd(reload_timer_pkg::ADDR_COUNT_HIGH, d);
        `CHK(d >= 8'ha0 && d <= 8'ha1, 1'b1);
        repeat (2) @(posedge clock);
        `CHK(irq_req, 1'b1);
        $display("test split done");
    endtask

    initial begin
        clock              = 1'b0;
        rstn               = 1'b0;
        req                = '0;
        high_sysclk_select = 1'b0;
        low_sysclk_select  = 1'b0;
        timer_irq_enable   = 1'b0;
        ext_osc            = 1'b0;
        errors             = 0;
        checked            = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        t_reset_map();
        t_sources();
        t_sixteen();
        t_split();
        final_report();
    end
endmodule // tb_top
